// [rec_pkg.sv]
// Package: register offsets, field layouts and decodes for the regulator enable/config slice
package rec_pkg;
    localparam logic [7:0] REG3_ENABLE_CONTROL_ADDR     = 8'h34;
    localparam logic [7:0] REG3_CONFIGURATION_ADDR      = 8'h35;
    localparam logic [7:0] REG2_SERIAL_VOLTAGE_RB_ADDR  = 8'h32;

    // Enable control layout
    localparam int SEQ_MSB = 7;
    localparam int SEQ_LSB = 5;
    localparam int SEL_MSB = 1;
    localparam int SEL_LSB = 0;

    // Configuration bit positions
    localparam int CFG_INTEGRATOR_DISABLE = 7;
    localparam int CFG_POWERGOOD_TRANS    = 6;
    localparam int CFG_FAST_PRETRIGGER    = 5;
    localparam int CFG_PASSIVE_DISCHARGE  = 4;
    localparam int CFG_ACTIVE_DISCHARGE   = 3;
    localparam int CFG_LOW_EMISSION       = 2;
    localparam int CFG_SWITCH_HALVING     = 1;
    localparam int CFG_FREEWHEEL_SENSE    = 0;

    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [1:0] SEL_RESET      = 2'h0;

    // Sequencing slot codes
    localparam logic [2:0] SEQ_DISABLED   = 3'h0;
    localparam logic [2:0] SEQ_AT_0PCT    = 3'h2;
    localparam logic [2:0] SEQ_AT_25PCT   = 3'h3;
    localparam logic [2:0] SEQ_AT_50PCT   = 3'h4;
    localparam logic [2:0] SEQ_SOFTWARE   = 3'h7;

    // Software enable selector codes
    localparam logic [1:0] SEL_DISABLED   = 2'h0;
    localparam logic [1:0] SEL_ENABLED    = 2'h1;
    localparam logic [1:0] SEL_PINS       = 2'h2;

    // Readback code: 0.55 V plus code times step, top code 63
    localparam int          VCODE_W       = 6;
    localparam int          VBASE_MV      = 550;
    localparam logic [5:0]  VCODE_MAX     = 6'h3F;
    localparam logic [7:0]  READ_ZERO     = 8'h00;
endpackage

// [rec_seq_timer.sv]
// Module: boot-delay progress tracker giving the 25/50/100 percent points
`timescale 1ns/1ps
module rec_seq_timer #(
    parameter int BOOT_CYCLES = 4000
) (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    // Progress points
    output logic      o_at_25,
    output logic      o_at_50,
    output logic      o_done
);
    localparam int CW = $clog2(BOOT_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(BOOT_CYCLES);
    localparam logic [CW-1:0] Q25  = CW'(BOOT_CYCLES / 4);
    localparam logic [CW-1:0] Q50  = CW'(BOOT_CYCLES / 2);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    assign count_next = (count_reg == LAST) ? count_reg : count_reg + CW'(1);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Counter saturates, so the points never fall back once reached until the next reset
    assign o_at_25 = (count_reg >= Q25);
    assign o_at_50 = (count_reg >= Q50);
    assign o_done  = (count_reg == LAST);
endmodule // rec_seq_timer

// [rec_regs.sv]
// Module: enable/configuration register slice for one step-down regulator channel
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module rec_regs
    import rec_pkg::*;
#(
    parameter int BOOT_CYCLES = 4000,
    parameter int NUM_PINS    = 4
) (
    // Clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst_n,
    // Register access port
    input  wire logic                i_reg_write,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic [7:0]          i_reg_wdata,
    output logic      [7:0]          o_reg_rdata,
    // Device state
    input  wire logic [2:0]          i_powerup_sequence_slot,
    input  wire logic [VCODE_W-1:0]  i_second_reg_serial_voltage_code,
    input  wire logic [NUM_PINS-1:0] i_multipurpose_control_pin,
    input  wire logic [NUM_PINS-1:0] i_pin_select,
    input  wire logic                i_hard_reset,
    input  wire logic                i_shutdown,
    // Regulator controls
    output logic                     o_regulator_enable,
    output logic                     o_active_discharge,
    output logic                     o_passive_discharge,
    output logic                     o_integrator_disable,
    output logic                     o_powergood_during_transition,
    output logic                     o_fast_transient_pretrigger,
    output logic                     o_low_emission_edges,
    output logic                     o_switch_size_halving,
    output logic                     o_freewheel_entry_sense
);
    import rec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]         software_enable_selector_reg;
    logic [7:0]         config_reg;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;
    logic               enable_reg;
    logic               enable_next;
    logic               act_dsc_reg;
    logic               psv_dsc_reg;
    logic               at_25;
    logic               at_50;
    logic               boot_done;

    wire  sel_en_wr = i_reg_write && (i_reg_addr == REG3_ENABLE_CONTROL_ADDR);
    wire  cfg_wr    = i_reg_write && (i_reg_addr == REG3_CONFIGURATION_ADDR);

    rec_seq_timer #(
        .BOOT_CYCLES (BOOT_CYCLES)
    ) u_timer (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .o_at_25 (at_25),
        .o_at_50 (at_50),
        .o_done  (boot_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Only the selector bits and the configuration byte are writable; slot and readback are inputs
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            software_enable_selector_reg <= SEL_RESET;
            config_reg                   <= CFG_RESET;
        end else begin
            if (sel_en_wr) begin
                software_enable_selector_reg <= i_reg_wdata[SEL_MSB:SEL_LSB];
            end
            if (cfg_wr) begin
                config_reg <= i_reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable decode
    wire pins_on = |(i_multipurpose_control_pin & i_pin_select);
    wire sel_on  = (software_enable_selector_reg == SEL_ENABLED) ||
                   ((software_enable_selector_reg == SEL_PINS) && pins_on);

    always_comb begin
        enable_next = 1'b0;
        case (i_powerup_sequence_slot)
            SEQ_AT_0PCT:  enable_next = 1'b1;
            SEQ_AT_25PCT: enable_next = at_25;
            SEQ_AT_50PCT: enable_next = at_50;
            SEQ_SOFTWARE: enable_next = boot_done && sel_on;
            default:      enable_next = 1'b0;
        endcase
    end

    wire off_mode = i_hard_reset || i_shutdown;
    // A low enable discharges when the matching option is set; shutdown or hard reset forces active, hard reset passive
    wire act_next = off_mode ||
                    (!enable_next && config_reg[CFG_ACTIVE_DISCHARGE]);
    wire psv_next = i_hard_reset ||
                    (!enable_next && config_reg[CFG_PASSIVE_DISCHARGE]);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable_reg  <= 1'b0;
            act_dsc_reg <= 1'b0;
            psv_dsc_reg <= 1'b0;
        end else begin
            enable_reg  <= enable_next;
            act_dsc_reg <= act_next;
            psv_dsc_reg <= psv_next;
        end
    end

    assign o_regulator_enable  = enable_reg;
    assign o_active_discharge  = act_dsc_reg;
    assign o_passive_discharge = psv_dsc_reg;

    assign o_integrator_disable          = config_reg[CFG_INTEGRATOR_DISABLE];
    assign o_powergood_during_transition = config_reg[CFG_POWERGOOD_TRANS];
    assign o_fast_transient_pretrigger   = config_reg[CFG_FAST_PRETRIGGER];
    assign o_low_emission_edges          = config_reg[CFG_LOW_EMISSION];
    assign o_switch_size_halving         = config_reg[CFG_SWITCH_HALVING];
    assign o_freewheel_entry_sense       = config_reg[CFG_FREEWHEEL_SENSE];

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits read zero, unmapped offsets read zero
    wire [7:0] ena_view = {i_powerup_sequence_slot, 3'h0, software_enable_selector_reg};
    wire [7:0] rb_view  = {2'h0, i_second_reg_serial_voltage_code};

    always_comb begin
        case (i_reg_addr)
            REG3_ENABLE_CONTROL_ADDR:    rdata_next = ena_view;
            REG3_CONFIGURATION_ADDR:     rdata_next = config_reg;
            REG2_SERIAL_VOLTAGE_RB_ADDR: rdata_next = rb_view;
            default:                     rdata_next = READ_ZERO;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= READ_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks that expect a registered output to rise also need the sampled reset high:
    // reset released on a clock edge still clears the registers at that edge, so an
    // attempt started there would be compared against the cleared value
    a_seq_disabled_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_powerup_sequence_slot == SEQ_DISABLED) |=> !o_regulator_enable)
        else $error("regulator on while slot disabled");
    a_zero_pct_on: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && i_powerup_sequence_slot == SEQ_AT_0PCT) |=> o_regulator_enable)
        else $error("slot 010 did not enable");
    a_quarter_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_powerup_sequence_slot == SEQ_AT_25PCT && !at_25) |=> !o_regulator_enable)
        else $error("quarter slot enabled early");
    a_boot_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_powerup_sequence_slot == SEQ_SOFTWARE && !boot_done) |=> !o_regulator_enable)
        else $error("selector acted before boot delay");
    a_selector_on: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && i_powerup_sequence_slot == SEQ_SOFTWARE && boot_done &&
         software_enable_selector_reg == SEL_ENABLED) |=> o_regulator_enable)
        else $error("selector 01 did not enable");
    a_pin_on: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && i_powerup_sequence_slot == SEQ_SOFTWARE && boot_done &&
         software_enable_selector_reg == SEL_PINS && pins_on) |=> o_regulator_enable)
        else $error("selected pin did not enable");
    a_pin_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_powerup_sequence_slot == SEQ_SOFTWARE && software_enable_selector_reg == SEL_PINS &&
         !pins_on) |=> !o_regulator_enable)
        else $error("regulator on with selected pins low");
    a_reserved_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_powerup_sequence_slot == SEQ_SOFTWARE && software_enable_selector_reg == 2'h3) |=>
        !o_regulator_enable)
        else $error("reserved selector enabled regulator");
    a_no_disc_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!off_mode && !config_reg[CFG_ACTIVE_DISCHARGE]) |=> !o_active_discharge)
        else $error("active discharge without cause");
    a_off_mode_disc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && off_mode) |=> o_active_discharge)
        else $error("no active discharge in hard reset or shutdown");
    a_act_disc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && !enable_next && config_reg[CFG_ACTIVE_DISCHARGE]) |=> o_active_discharge)
        else $error("active discharge missing");
    a_psv_disc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && !enable_next && config_reg[CFG_PASSIVE_DISCHARGE]) |=> o_passive_discharge)
        else $error("passive discharge missing");
    a_psv_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_hard_reset && !config_reg[CFG_PASSIVE_DISCHARGE]) |=> !o_passive_discharge)
        else $error("passive discharge outside hard reset");
    a_cfg_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && cfg_wr) |=> (o_integrator_disable == $past(i_reg_wdata[CFG_INTEGRATOR_DISABLE]) &&
                    o_fast_transient_pretrigger == $past(i_reg_wdata[CFG_FAST_PRETRIGGER])))
        else $error("config write not applied");
    a_cfg_others: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && cfg_wr) |=> (o_powergood_during_transition == $past(i_reg_wdata[CFG_POWERGOOD_TRANS]) &&
                    o_low_emission_edges == $past(i_reg_wdata[CFG_LOW_EMISSION]) &&
                    o_freewheel_entry_sense == $past(i_reg_wdata[CFG_FREEWHEEL_SENSE])))
        else $error("config option bits not applied");
    a_rb_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && i_reg_addr == REG2_SERIAL_VOLTAGE_RB_ADDR) |=>
        (o_reg_rdata == {2'h0, $past(i_second_reg_serial_voltage_code)}))
        else $error("readback mismatch");
    a_slot_ro: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && i_reg_addr == REG3_ENABLE_CONTROL_ADDR) |=>
        (o_reg_rdata[SEQ_MSB:SEQ_LSB] == $past(i_powerup_sequence_slot)))
        else $error("slot read not from device state");
    a_sel_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && sel_en_wr) |=> (software_enable_selector_reg == $past(i_reg_wdata[SEL_MSB:SEL_LSB])))
        else $error("selector write not applied");
endmodule // rec_regs

// [rec_host.sv]
// Host model issuing single-byte register writes and addressed reads
`timescale 1ns/1ps
module rec_host (
    // Clock
    input  wire logic       i_clock,
    // Register access port
    input  wire logic [7:0] i_reg_rdata,
    output logic            o_reg_write,
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata
);
    initial begin
        o_reg_write = 1'b0;
        o_reg_addr  = 8'hFF;
        o_reg_wdata = 8'h00;
    end
    // Strobe lasts one edge; stale data is inverted so nothing leans on it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_reg_write <= 1'b1;
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        @(posedge i_clock);
        o_reg_write <= 1'b0;
        o_reg_wdata <= ~d;
    endtask
    // Read data is registered, so it follows the address one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_reg_addr <= a;
        @(posedge i_clock);
        #1 d = i_reg_rdata;
    endtask
endmodule // rec_host

// [regulator_enable_config_regs_tb_top.sv]
// Self-checking testbench for the regulator enable/config register slice
`timescale 1ns/1ps
module regulator_enable_config_regs_tb_top;
    import rec_pkg::*;
    logic        i_clock, i_rst_n, reg_write, hard_reset, shutdown, exp_en;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
    logic [2:0]  slot;
    logic [5:0]  vcode;
    logic [3:0]  pins, pin_sel;
    logic        en, act_dsc, psv_dsc, integ, pg, fast, low_em, halving, fw;
    int          num_errors, checks;
    // Row: configuration byte, then bits 7,6,5,2,1,0 expected at the outputs
    logic [13:0] rows [4] = '{{8'hA5, 6'h2D}, {8'h5A, 6'h12}, {8'hFF, 6'h3F}, {8'h00, 6'h00}};

    rec_regs #(.BOOT_CYCLES(40), .NUM_PINS(4)) uut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_write(reg_write), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_powerup_sequence_slot(slot),
        .i_second_reg_serial_voltage_code(vcode), .i_multipurpose_control_pin(pins),
        .i_pin_select(pin_sel), .i_hard_reset(hard_reset), .i_shutdown(shutdown),
        .o_regulator_enable(en), .o_active_discharge(act_dsc), .o_passive_discharge(psv_dsc),
        .o_integrator_disable(integ), .o_powergood_during_transition(pg),
        .o_fast_transient_pretrigger(fast), .o_low_emission_edges(low_em),
        .o_switch_size_halving(halving), .o_freewheel_entry_sense(fw));
    rec_host host (.i_clock(i_clock), .i_reg_rdata(reg_rdata), .o_reg_write(reg_write),
                   .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        num_errors = 0;
        checks = 0;
        i_rst_n = 1'b0;
        slot = SEQ_SOFTWARE;
        vcode = 6'h2A;
        pins = 4'h0;
        pin_sel = 4'h4;
        hard_reset = 1'b0;
        shutdown = 1'b0;
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        host.rd(REG3_CONFIGURATION_ADDR, rd_val);
        chk("cfg after reset", rd_val, CFG_RESET);
        host.wr(REG3_ENABLE_CONTROL_ADDR, 8'h01);
        tick(3);
        chk("enable before boot", {7'h0, en}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            host.wr(REG3_CONFIGURATION_ADDR, rows[i][13:6]);
            host.rd(REG3_CONFIGURATION_ADDR, rd_val);
            chk("cfg readback", rd_val, rows[i][13:6]);
            chk("cfg outputs", {2'h0, integ, pg, fast, low_em, halving, fw}, {2'h0, rows[i][5:0]});
        end
        // Discharge bits set so that every selector step with enable low also shows discharge
        host.wr(REG3_CONFIGURATION_ADDR, 8'h18);
        tick(30);
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clock);
            pins <= k[0] ? 4'h4 : 4'hB;
            host.wr(REG3_ENABLE_CONTROL_ADDR, {6'h00, k[2:1]});
            tick(2);
            exp_en = (k[2:1] == 2'h1) || (k[2:1] == 2'h2 && k[0]);
            chk("enable", {7'h0, en}, {7'h0, exp_en});
            chk("discharge", {6'h0, act_dsc, psv_dsc}, {6'h0, !exp_en, !exp_en});
        end
        host.wr(REG3_ENABLE_CONTROL_ADDR, 8'h00);
        host.wr(REG3_CONFIGURATION_ADDR, 8'h00);
        tick(2);
        chk("no discharge", {6'h0, act_dsc, psv_dsc}, 8'h00);
        @(posedge i_clock);
        shutdown <= 1'b1;
        tick(2);
        chk("shutdown discharge", {6'h0, act_dsc, psv_dsc}, 8'h02);
        @(posedge i_clock);
        shutdown <= 1'b0;
        hard_reset <= 1'b1;
        tick(2);
        chk("hard reset discharge", {6'h0, act_dsc, psv_dsc}, 8'h03);
        @(posedge i_clock);
        hard_reset <= 1'b0;
        // Read-only fields must survive writes
        host.wr(REG3_ENABLE_CONTROL_ADDR, 8'hFF);
        host.wr(REG2_SERIAL_VOLTAGE_RB_ADDR, 8'h15);
        host.rd(REG3_ENABLE_CONTROL_ADDR, rd_val);
        chk("enable ctrl", rd_val, 8'hE3);
        host.rd(REG2_SERIAL_VOLTAGE_RB_ADDR, rd_val);
        chk("voltage code", rd_val, 8'h2A);
        @(posedge i_clock);
        vcode <= VCODE_MAX;
        host.rd(REG2_SERIAL_VOLTAGE_RB_ADDR, rd_val);
        chk("top voltage code", rd_val, 8'h3F);
        host.rd(8'h40, rd_val);
        chk("unmapped", rd_val, READ_ZERO);
        for (int s = 0; s < 7; s++) begin
            @(posedge i_clock);
            slot <= s[2:0];
            host.rd(REG3_ENABLE_CONTROL_ADDR, rd_val);
            chk("slot field", rd_val, {s[2:0], 5'h03});
            chk("slot enable", {7'h0, en}, {7'h0, s >= 2 && s <= 4});
        end
        // Second reset restarts the boot delay: the quarter point comes again
        @(posedge i_clock);
        slot <= SEQ_AT_25PCT;
        i_rst_n <= 1'b0;
        tick(3);
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        tick(4);
        chk("early quarter slot", {7'h0, en}, 8'h00);
        tick(12);
        chk("late quarter slot", {7'h0, en}, 8'h01);
        tally_and_finish();
    end
endmodule // regulator_enable_config_regs_tb_top
